// File: include/ixp_pkg.sv
// Constants shared by the indexer positioning command logic.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
package ixp_pkg;
	// ********************
	// Register byte addresses
	// ********************
	localparam logic [7:0] IXP_ADDR_MOTION_MODE = 8'h00;
	localparam logic [7:0] IXP_ADDR_SPEED_SRC = 8'h04;
	localparam logic [7:0] IXP_ADDR_STATION_DIR = 8'h08;
	localparam logic [7:0] IXP_ADDR_STATION_COUNT = 8'h0c;
	localparam logic [7:0] IXP_ADDR_LINK_CFG = 8'h10;
	localparam logic [7:0] IXP_ADDR_STATUS = 8'h14;
	localparam logic [7:0] IXP_ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] IXP_ADDR_IRQ_CLEAR = 8'h1c;
	localparam logic [7:0] IXP_ADDR_IRQ_ENABLE = 8'h20;
	localparam logic [7:0] IXP_ADDR_LATCHED = 8'h24;
	// Point table window: bit 7 set, entry in bits 6:4, field in bits 3:2
	localparam int IXP_TABLE_SEL_BIT = 7;
	localparam logic [1:0] IXP_FIELD_SPEED = 2'h0;
	localparam logic [1:0] IXP_FIELD_ACCEL = 2'h1;
	localparam logic [1:0] IXP_FIELD_DECEL = 2'h2;

	// ********************
	// Field values and reset values
	// ********************
	localparam logic [11:0] IXP_INDEXER_MODE_CODE = 12'h111;
	localparam int IXP_SPEED_SRC_LSB = 4;
	localparam logic [3:0] IXP_SPEED_SRC_DIRECT = 4'h1;
	localparam logic [15:0] IXP_MOTION_MODE_RESET = 16'h0000;
	localparam logic [15:0] IXP_SPEED_SRC_RESET = 16'h0000;
	localparam logic [15:0] IXP_STATION_COUNT_RESET = 16'h0008;
	localparam logic [15:0] IXP_TIME_CONST_MAX_MS = 16'h4e20;

	// Event bits of the interrupt status, clear and enable registers
	localparam int IXP_EV_WARN = 0;
	localparam int IXP_EV_ALARM = 1;
	localparam int IXP_EV_DONE = 2;
	localparam int IXP_EV_IGNORED = 3;
	localparam int IXP_EV_BAD_TABLE = 4;
	localparam int IXP_EV_COUNT = 5;

	localparam logic [1:0] IXP_RESP_OKAY = 2'h0;
	localparam logic [1:0] IXP_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		IXP_IDLE = 2'b00,
		IXP_MOVING = 2'b01
	} ixp_state_t;
endpackage

// File: hdl/ixp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes a multi-bit group is held stable well before it is used.
`timescale 1ns/1ns
`default_nettype none
module ixp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;

	// ********************
	// First stage is read only by the second
	// ********************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1_reg <= '0;
			syncOut <= '0;
		end else begin
			stage1_reg <= pinIn;
			syncOut <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// File: hdl/ixp_point_table.sv
// Eight point tables of speed and two time constants, held in flip-flops.
// Assumes the caller merges byte enables before writing a whole field.
`timescale 1ns/1ns
`default_nettype none
module ixp_point_table
	import ixp_pkg::*;
#(
	parameter int ENTRIES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic writeEn,
	input wire logic [2:0] writeIndex,
	input wire logic [1:0] writeField,
	input wire logic [15:0] writeData,
	output logic [ENTRIES*48-1:0] tableFlat
);
	// ********************
	// One entry per point table
	// ********************
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : gEntry
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					tableFlat[g*48 +: 48] <= '0;
				end else if (writeEn && writeIndex == 3'(g)) begin
					case (writeField)
						IXP_FIELD_SPEED: tableFlat[g*48 +: 16] <= writeData;
						// Time constants saturate at the upper limit
						IXP_FIELD_ACCEL: tableFlat[g*48+16 +: 16] <=
							(writeData > IXP_TIME_CONST_MAX_MS) ? IXP_TIME_CONST_MAX_MS : writeData;
						IXP_FIELD_DECEL: tableFlat[g*48+32 +: 16] <=
							(writeData > IXP_TIME_CONST_MAX_MS) ? IXP_TIME_CONST_MAX_MS : writeData;
						default: ;
					endcase
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: hdl/ixp_indexer_cmd.sv
// Indexer positioning command logic: AXI4-Lite registers, start handling,
// point table lookup and command output to the motion engine.
// Assumes fieldbus bits arrive from pins; the motion engine and homing
// status run on ref_clk.
// Behaviour
// - Indexer runs only when mode code 111
// - Speed source digit picks table or word
// - Station number comes from next-station word
// - Table/speed word is table number or speed
// - Eight tables hold speed, accel, decel
// - Time constants limited to 0 to 20000 ms
// - Direct speed only with two stations occupied
// - Table mode start uses selected table
// - Direct mode start uses word, table one
// - Station count and direction from parameters
// - Start ignored while a move runs
// - Warn when station exceeds count minus one
// - Alarm when start comes before homing
`timescale 1ns/1ns
`default_nettype none
module ixp_indexer_cmd
	import ixp_pkg::*;
#(
	parameter int ENTRIES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic motionStartBit,
	input wire logic opModeSelectOne,
	input wire logic opModeSelectTwo,
	input wire logic posSpeedSourceSelect,
	input wire logic [15:0] nextStationWord,
	input wire logic [15:0] tableOrSpeedWord,
	input wire logic homeDone,
	input wire logic motionDone,
	output logic moveStart,
	output logic [15:0] cmdStation,
	output logic [15:0] cmdSpeed,
	output logic [15:0] cmdAccelMs,
	output logic [15:0] cmdDecelMs,
	output logic cmdDirection,
	output logic moveDoneFlag,
	output logic nextStationWarning,
	output logic homeIncompleteAlarm,
	output logic irq
);
	// ********************
	// Pin synchronisation
	// ********************
	logic [35:0] pinSync;
	logic startSync, modeOneSync, modeTwoSync, srcSelSync;
	logic [15:0] stationSync, tableSpeedSync;

	// Words cross bit by bit; the master changes them well ahead of start
	ixp_sync #(.WIDTH(36)) uSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pinIn({motionStartBit, opModeSelectOne, opModeSelectTwo, posSpeedSourceSelect,
			nextStationWord, tableOrSpeedWord}),
		.syncOut(pinSync)
	);
	assign {startSync, modeOneSync, modeTwoSync, srcSelSync, stationSync, tableSpeedSync} = pinSync;

	// ********************
	// Register state
	// ********************
	logic [15:0] motionMode_reg, speedSrc_reg, stationCount_reg;
	logic stationDir_reg, twoStations_reg;
	logic [IXP_EV_COUNT-1:0] irqStatus_reg, irqEnable_reg;
	logic [IXP_EV_COUNT-1:0] events, clearMask;
	logic [ENTRIES*48-1:0] tableFlat;

	logic awHeld_reg, wHeld_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;
	logic [31:0] writeMerged;
	logic writeHit, readHit;
	logic [31:0] readValue, oldValue;

	ixp_state_t state_reg;
	logic startPrev_reg;
	logic startRise;
	logic [15:0] latchStation_reg, latchTableSpeed_reg;
	logic indexerActive, directSpeed, stationBad, tableBad, acceptNow;
	logic [2:0] tableIndex;

	// ********************
	// Register readback
	// ********************
	function automatic logic [31:0] regValue(input logic [7:0] a);
		logic [2:0] idx;
		logic [31:0] v;
		idx = a[6:4];
		v = '0;
		if (a[IXP_TABLE_SEL_BIT]) begin
			case (a[3:2])
				IXP_FIELD_SPEED: v = {16'h0000, tableFlat[idx*48 +: 16]};
				IXP_FIELD_ACCEL: v = {16'h0000, tableFlat[idx*48+16 +: 16]};
				IXP_FIELD_DECEL: v = {16'h0000, tableFlat[idx*48+32 +: 16]};
				default: v = '0;
			endcase
		end else begin
			case (a)
				IXP_ADDR_MOTION_MODE: v = {16'h0000, motionMode_reg};
				IXP_ADDR_SPEED_SRC: v = {16'h0000, speedSrc_reg};
				IXP_ADDR_STATION_DIR: v = {31'h0, stationDir_reg};
				IXP_ADDR_STATION_COUNT: v = {16'h0000, stationCount_reg};
				IXP_ADDR_LINK_CFG: v = {31'h0, twoStations_reg};
				IXP_ADDR_STATUS: v = {28'h0, homeDone, moveDoneFlag, indexerActive,
					state_reg == IXP_MOVING};
				IXP_ADDR_IRQ_STATUS: v = {27'h0, irqStatus_reg};
				IXP_ADDR_IRQ_ENABLE: v = {27'h0, irqEnable_reg};
				IXP_ADDR_LATCHED: v = {latchTableSpeed_reg, latchStation_reg};
				default: v = '0;
			endcase
		end
		return v;
	endfunction

	function automatic logic addrMapped(input logic [7:0] a, input logic forWrite);
		logic hit;
		hit = 1'b0;
		if (a[IXP_TABLE_SEL_BIT]) begin
			hit = (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
		end else begin
			case (a)
				IXP_ADDR_MOTION_MODE, IXP_ADDR_SPEED_SRC, IXP_ADDR_STATION_DIR,
				IXP_ADDR_STATION_COUNT, IXP_ADDR_LINK_CFG, IXP_ADDR_IRQ_ENABLE: hit = 1'b1;
				IXP_ADDR_STATUS, IXP_ADDR_IRQ_STATUS, IXP_ADDR_LATCHED: hit = !forWrite;
				IXP_ADDR_IRQ_CLEAR: hit = forWrite;
				default: hit = 1'b0;
			endcase
		end
		return hit;
	endfunction

	// ********************
	// AXI4-Lite write channel
	// ********************
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign writeHit = addrMapped(awAddr_reg, 1'b1);
	assign oldValue = regValue(awAddr_reg);

	always_comb begin
		writeMerged = oldValue;
		for (int b = 0; b < 4; b++) begin
			if (wStrb_reg[b]) begin
				writeMerged[b*8 +: 8] = wData_reg[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= IXP_RESP_OKAY;
		end else begin
			// Ready is offered one cycle after valid so each beat is taken once
			s_axi_awready <= !awHeld_reg && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !wHeld_reg && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeHit ? IXP_RESP_OKAY : IXP_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
			end
		end
	end

	// ********************
	// Configuration registers
	// ********************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			motionMode_reg <= IXP_MOTION_MODE_RESET;
			speedSrc_reg <= IXP_SPEED_SRC_RESET;
			stationDir_reg <= 1'b0;
			stationCount_reg <= IXP_STATION_COUNT_RESET;
			twoStations_reg <= 1'b0;
			irqEnable_reg <= '0;
		end else if (doWrite && writeHit && !awAddr_reg[IXP_TABLE_SEL_BIT]) begin
			case (awAddr_reg)
				IXP_ADDR_MOTION_MODE: motionMode_reg <= writeMerged[15:0];
				IXP_ADDR_SPEED_SRC: speedSrc_reg <= writeMerged[15:0];
				IXP_ADDR_STATION_DIR: stationDir_reg <= writeMerged[0];
				IXP_ADDR_STATION_COUNT: stationCount_reg <= writeMerged[15:0];
				IXP_ADDR_LINK_CFG: twoStations_reg <= writeMerged[0];
				IXP_ADDR_IRQ_ENABLE: irqEnable_reg <= writeMerged[IXP_EV_COUNT-1:0];
				default: ;
			endcase
		end
	end

	ixp_point_table #(.ENTRIES(ENTRIES)) uTable (
		.ref_clk(ref_clk),
		.rst(rst),
		.writeEn(doWrite && writeHit && awAddr_reg[IXP_TABLE_SEL_BIT]),
		.writeIndex(awAddr_reg[6:4]),
		.writeField(awAddr_reg[3:2]),
		.writeData(writeMerged[15:0]),
		.tableFlat(tableFlat)
	);

	// ********************
	// AXI4-Lite read channel
	// ********************
	assign readHit = addrMapped(s_axi_araddr, 1'b0);
	assign readValue = regValue(s_axi_araddr);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= IXP_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readHit ? readValue : 32'h0000_0000;
				s_axi_rresp <= readHit ? IXP_RESP_OKAY : IXP_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ********************
	// Start qualification
	// ********************

	// Mode bits and source select are the master's duty; we only check them
	assign indexerActive = (motionMode_reg[11:0] == IXP_INDEXER_MODE_CODE)
		&& !modeOneSync && modeTwoSync && srcSelSync;
	// Direct speed needs the wider two-station register set
	assign directSpeed = (speedSrc_reg[IXP_SPEED_SRC_LSB +: 4] == IXP_SPEED_SRC_DIRECT)
		&& twoStations_reg;
	// Compared directly so that station 16'hffff cannot wrap past the check
	assign stationBad = stationSync >= stationCount_reg;
	assign tableBad = !directSpeed && (tableSpeedSync == 16'h0000 || tableSpeedSync > 16'(ENTRIES));
	// Table numbers count from one; direct mode always reads table one
	assign tableIndex = directSpeed ? 3'h0 : 3'(tableSpeedSync - 16'h0001);
	assign startRise = startSync && !startPrev_reg;
	assign acceptNow = (state_reg == IXP_IDLE) && startRise && indexerActive && homeDone && !stationBad && !tableBad;

	always_comb begin
		events = '0;
		if (startRise && indexerActive) begin
			if (state_reg == IXP_MOVING) begin
				events[IXP_EV_IGNORED] = 1'b1;
			end else if (!homeDone) begin
				events[IXP_EV_ALARM] = 1'b1;
			end else if (stationBad) begin
				events[IXP_EV_WARN] = 1'b1;
			end else if (tableBad) begin
				events[IXP_EV_BAD_TABLE] = 1'b1;
			end
		end
		events[IXP_EV_DONE] = (state_reg == IXP_MOVING) && motionDone;
	end

	// ********************
	// Move sequence
	// ********************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= IXP_IDLE;
			startPrev_reg <= 1'b0;
			latchStation_reg <= '0;
			latchTableSpeed_reg <= '0;
			moveStart <= 1'b0;
			cmdStation <= '0;
			cmdSpeed <= '0;
			cmdAccelMs <= '0;
			cmdDecelMs <= '0;
			cmdDirection <= 1'b0;
			moveDoneFlag <= 1'b0;
		end else begin
			startPrev_reg <= startSync;
			moveStart <= 1'b0;
			case (state_reg)
				IXP_IDLE: begin
					if (acceptNow) begin
						// Words are frozen here; later changes wait for the next start
						latchStation_reg <= stationSync;
						latchTableSpeed_reg <= tableSpeedSync;
						cmdStation <= stationSync;
						cmdSpeed <= directSpeed ? tableSpeedSync : tableFlat[tableIndex*48 +: 16];
						cmdAccelMs <= tableFlat[tableIndex*48+16 +: 16];
						cmdDecelMs <= tableFlat[tableIndex*48+32 +: 16];
						cmdDirection <= stationDir_reg;
						moveStart <= 1'b1;
						moveDoneFlag <= 1'b0;
						state_reg <= IXP_MOVING;
					end
				end
				IXP_MOVING: begin
					if (motionDone) begin
						moveDoneFlag <= 1'b1;
						state_reg <= IXP_IDLE;
					end
				end
				default: state_reg <= IXP_IDLE;
			endcase
		end
	end

	// ********************
	// Warning and alarm levels
	// ********************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nextStationWarning <= 1'b0;
			homeIncompleteAlarm <= 1'b0;
		end else begin
			if (events[IXP_EV_WARN]) begin
				nextStationWarning <= 1'b1;
			end else if (acceptNow) begin
				// Cleared at the accepting edge so the level is low with moveStart
				nextStationWarning <= 1'b0;
			end
			if (events[IXP_EV_ALARM]) begin
				homeIncompleteAlarm <= 1'b1;
			end else if (acceptNow) begin
				homeIncompleteAlarm <= 1'b0;
			end
		end
	end

	// ********************
	// Interrupt status
	// ********************
	assign clearMask = (doWrite && awAddr_reg == IXP_ADDR_IRQ_CLEAR)
		? writeMerged[IXP_EV_COUNT-1:0] : '0;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irqStatus_reg <= '0;
			irq <= 1'b0;
		end else begin
			// An event in the clearing cycle survives the clear
			irqStatus_reg <= (irqStatus_reg & ~clearMask) | events;
			irq <= |(((irqStatus_reg & ~clearMask) | events) & irqEnable_reg);
		end
	end
endmodule
`default_nettype wire

// File: bench/ixp_indexer_cmd_props.sv
// Concurrent checks on the indexer command block's ports.
// Assumes it is bound to ixp_indexer_cmd and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module ixp_indexer_cmd_props
	import ixp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic motionStartBit,
	input wire logic homeDone,
	input wire logic motionDone,
	input wire logic moveStart,
	input wire logic [15:0] cmdStation,
	input wire logic [15:0] cmdSpeed,
	input wire logic [15:0] cmdAccelMs,
	input wire logic [15:0] cmdDecelMs,
	input wire logic moveDoneFlag,
	input wire logic nextStationWarning,
	input wire logic homeIncompleteAlarm
);
	// ********************
	// Move tracking and properties
	// ********************
	logic movingReg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			movingReg <= 1'b0;
		end else if (motionDone) begin
			// A done in the accept cycle ends the move as the block does
			movingReg <= 1'b0;
		end else if (moveStart) begin
			movingReg <= 1'b1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_accept;
		moveStart ##1 !moveStart;
	endsequence
	sequence s_hold;
		$stable(cmdStation) && $stable(cmdSpeed) && $stable(cmdAccelMs) && $stable(cmdDecelMs);
	endsequence
	a_start_one_pulse: assert property (moveStart |-> s_accept) else $error("accept pulse too long");
	a_busy_refuse: assert property (movingReg |-> !moveStart) else $error("start taken while moving");
	a_done_sets_flag: assert property (motionDone && movingReg |=> moveDoneFlag) else $error("done flag missing");
	a_flag_stays: assert property (moveDoneFlag |=> moveDoneFlag || moveStart) else $error("done flag dropped");
	a_accept_clears: assert property (moveStart |-> !moveDoneFlag && !nextStationWarning && !homeIncompleteAlarm)
		else $error("accept left a flag set");
	a_home_needed: assert property (moveStart |-> $past(homeDone)) else $error("accept without homing");
	a_start_edge: assert property (moveStart |-> $past(motionStartBit, 3) && !$past(motionStartBit, 4))
		else $error("accept without start pin");
	a_cmd_hold: assert property (!moveStart |-> s_hold) else $error("command changed between accepts");
	a_time_limit: assert property (moveStart |-> cmdAccelMs <= IXP_TIME_CONST_MAX_MS && cmdDecelMs <= IXP_TIME_CONST_MAX_MS)
		else $error("time constant above limit");
endmodule
bind ixp_indexer_cmd ixp_indexer_cmd_props u_props (.ref_clk(ref_clk), .rst(rst), .motionStartBit(motionStartBit),
	.homeDone(homeDone), .motionDone(motionDone), .moveStart(moveStart), .cmdStation(cmdStation), .cmdSpeed(cmdSpeed),
	.cmdAccelMs(cmdAccelMs), .cmdDecelMs(cmdDecelMs), .moveDoneFlag(moveDoneFlag),
	.nextStationWarning(nextStationWarning), .homeIncompleteAlarm(homeIncompleteAlarm));
`default_nettype wire

// File: bench/ixp_master_model.sv
// Fieldbus master model driving start, mode bits and command words.
// Assumes the bench requests a start with go and holds it until busy.
`timescale 1ns/1ns
`default_nettype none
module ixp_master_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic eager,
	input wire logic [2:0] modeBits,
	input wire logic [15:0] stn,
	input wire logic [15:0] tsw,
	input wire logic moveDoneFlag,
	output logic motionStartBit,
	output logic opModeSelectOne,
	output logic opModeSelectTwo,
	output logic posSpeedSourceSelect,
	output logic [15:0] nextStationWord,
	output logic [15:0] tableOrSpeedWord,
	output logic busy
);
	logic [3:0] cntReg;
	logic waitReg;
	logic [15:0] stnReg;
	logic [15:0] tswReg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cntReg <= 4'h0;
			waitReg <= 1'b0;
			stnReg <= 16'h0;
			tswReg <= 16'h0;
		end else begin
			if (moveDoneFlag && !busy) begin
				waitReg <= 1'b0;
			end
			// Eager starts break the wait on purpose for refusal scenarios
			if (go && !busy && (eager || !waitReg)) begin
				cntReg <= 4'h9;
				stnReg <= stn;
				tswReg <= tsw;
				waitReg <= !eager;
			end else if (busy) begin
				cntReg <= cntReg - 4'h1;
			end
		end
	end
	assign busy = cntReg != 4'h0;
	assign motionStartBit = cntReg >= 4'h4 && cntReg <= 4'h8;
	// Words are inverted once busy ends, three cycles after the start pin drops, so late sampling shows up
	assign nextStationWord = busy ? stnReg : ~stnReg;
	assign tableOrSpeedWord = busy ? tswReg : ~tswReg;
	assign {opModeSelectOne, opModeSelectTwo, posSpeedSourceSelect} = modeBits;
endmodule
`default_nettype wire

// File: bench/ixp_indexer_cmd_tb_top.sv
// Self-checking bench for the indexer command block.
// Assumes the master model and bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module ixp_indexer_cmd_tb_top
	import ixp_pkg::*;
;
	logic ref_clk = 0, rst = 1, go = 0, eager = 0, homeDone = 0, motionDone = 0;
	logic [2:0] modeBits = 3'b011;
	logic [15:0] stn = 0, tsw = 0, nsw, tosw, cmdStation, cmdSpeed, cmdAccelMs, cmdDecelMs, w;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, got, startPin, sel1, sel2, srcSel;
	logic moveStart, cmdDirection, moveDoneFlag, nextStationWarning, homeIncompleteAlarm, irq, busy;
	logic [15:0] spd[8], acc[8], dcl[8];
	int failures = 0, comparisons = 0, cyc = 0;
	always #20 ref_clk = ~ref_clk;
	ixp_indexer_cmd dut_u (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.motionStartBit(startPin), .opModeSelectOne(sel1), .opModeSelectTwo(sel2), .posSpeedSourceSelect(srcSel),
		.nextStationWord(nsw), .tableOrSpeedWord(tosw), .homeDone(homeDone), .motionDone(motionDone),
		.moveStart(moveStart), .cmdStation(cmdStation), .cmdSpeed(cmdSpeed), .cmdAccelMs(cmdAccelMs),
		.cmdDecelMs(cmdDecelMs), .cmdDirection(cmdDirection), .moveDoneFlag(moveDoneFlag),
		.nextStationWarning(nextStationWarning), .homeIncompleteAlarm(homeIncompleteAlarm), .irq(irq));
	ixp_master_model master_u (.ref_clk(ref_clk), .rst(rst), .go(go), .eager(eager), .modeBits(modeBits), .stn(stn),
		.tsw(tsw), .moveDoneFlag(moveDoneFlag), .motionStartBit(startPin), .opModeSelectOne(sel1),
		.opModeSelectTwo(sel2), .posSpeedSourceSelect(srcSel), .nextStationWord(nsw), .tableOrSpeedWord(tosw), .busy(busy));
	// ********************
	// Helpers
	// ********************
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		comparisons++;
		if (seen !== expv) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
		end
	endtask
	function automatic logic [15:0] satTc(input logic [15:0] v);
		return (v > IXP_TIME_CONST_MAX_MS) ? IXP_TIME_CONST_MAX_MS : v;
	endfunction
	task automatic wrap_up();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 30000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, wd;
		aw = 0;
		wd = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && wd)) begin
			@(posedge ref_clk);
			if (s_axi_awready) begin
				aw = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge ref_clk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic run(input logic [15:0] st, input logic [15:0] ts, input logic e);
		got = 0;
		@(posedge ref_clk);
		stn <= st;
		tsw <= ts;
		eager <= e;
		go <= 1;
		do @(posedge ref_clk); while (!busy);
		go <= 0;
		repeat (12) begin
			@(posedge ref_clk);
			#1;
			got = got | moveStart;
		end
		while (busy) @(posedge ref_clk);
	endtask
	task automatic finish_move();
		@(posedge ref_clk);
		motionDone <= 1;
		@(posedge ref_clk);
		motionDone <= 0;
		repeat (3) @(posedge ref_clk);
		chk(moveDoneFlag, 1);
		chk(irq, 1);
		axw(IXP_ADDR_IRQ_CLEAR, 32'h1 << IXP_EV_DONE);
		repeat (3) @(posedge ref_clk);
		chk(irq, 0);
	endtask
	// ********************
	// Scenarios
	// ********************
	initial begin
		void'($urandom(32'hbf3e));
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		axr(IXP_ADDR_STATION_COUNT);
		chk(rd, 32'h8);
		axr(8'h28);
		chk(resp, IXP_RESP_SLVERR);
		axw(IXP_ADDR_STATUS, 32'h1);
		chk(resp, IXP_RESP_SLVERR);
		axw(IXP_ADDR_MOTION_MODE, 32'h111);
		run(0, 1, 1);
		chk({got, homeIncompleteAlarm}, 2'b01);
		homeDone <= 1;
		for (int i = 0; i < 8; i++) begin
			spd[i] = 16'($urandom % 3000);
			acc[i] = (i == 7) ? 16'hffff : 16'($urandom % 25000);
			dcl[i] = 16'($urandom % 25000);
			axw(8'h80 + 8'(i * 16), spd[i]);
			axw(8'h84 + 8'(i * 16), acc[i]);
			axw(8'h88 + 8'(i * 16), dcl[i]);
			acc[i] = satTc(acc[i]);
			dcl[i] = satTc(dcl[i]);
			axr(8'h84 + 8'(i * 16));
			chk(rd, acc[i]);
		end
		axw(IXP_ADDR_IRQ_ENABLE, 32'h1 << IXP_EV_DONE);
		for (int i = 0; i < 8; i++) begin
			w = 16'($urandom % 8);
			axw(IXP_ADDR_STATION_DIR, i % 2);
			run(w, 16'(i + 1), 0);
			chk(got, 1);
			chk({cmdStation, cmdSpeed, cmdAccelMs, cmdDecelMs}, {w, spd[i], acc[i], dcl[i]});
			chk(cmdDirection, i % 2);
			finish_move();
		end
		axw(IXP_ADDR_STATION_COUNT, 32'h5);
		run(5, 1, 1);
		chk({got, nextStationWarning, irq}, 3'b010);
		run(4, 1, 0);
		chk(got, 1);
		finish_move();
		run(1, 0, 1);
		axr(IXP_ADDR_IRQ_STATUS);
		chk({got, rd[IXP_EV_BAD_TABLE]}, 2'b01);
		run(1, 2, 0);
		run(2, 3, 1);
		axr(IXP_ADDR_IRQ_STATUS);
		chk({got, cmdStation, rd[IXP_EV_IGNORED]}, {1'b0, 16'h1, 1'b1});
		finish_move();
		modeBits <= 3'b111;
		run(1, 1, 1);
		chk(got, 0);
		modeBits <= 3'b011;
		axw(IXP_ADDR_SPEED_SRC, 32'h1 << IXP_SPEED_SRC_LSB);
		run(2, 3, 0);
		chk({got, cmdSpeed}, {1'b1, spd[2]});
		finish_move();
		axw(IXP_ADDR_LINK_CFG, 32'h1);
		w = 16'($urandom % 3000 + 100);
		run(3, w, 0);
		chk({got, cmdStation, cmdSpeed, cmdAccelMs, cmdDecelMs}, {1'b1, 16'h3, w, acc[0], dcl[0]});
		finish_move();
		axw(IXP_ADDR_MOTION_MODE, 32'h112);
		run(1, 1, 1);
		chk(got, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
